// ==== logic/cfbank_pkg.sv ====
// constants, types and shared functions of the configurable flip-flop bank
package cfbank_pkg;

   localparam int NUM_BITS = 4;

   // clock and timing
   localparam int CLK_PERIOD_NS = 25;

   // register byte addresses
   localparam logic [7:0] ADDR_CFG    = 8'h00;
   localparam logic [7:0] ADDR_OUTSEL = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;

   // fields of the configuration register
   localparam int CFG_MS_BIT       = 0;
   localparam int CFG_CAP_INV_BIT  = 1;
   localparam int CFG_XFER_INV_BIT = 2;
   localparam int CFG_CLR_EN_BIT   = 3;
   localparam int CFG_PRE_EN_BIT   = 4;
   localparam int CFG_CLR_LOW_BIT  = 5;
   localparam int CFG_PRE_LOW_BIT  = 6;
   localparam int CFG_CODE_T_LSB   = 8;
   localparam int CFG_CODE_C_LSB   = 12;
   localparam int CFG_EQN_LSB      = 16;
   localparam logic [31:0] CFG_WMASK = 32'h0003_777F;
   localparam logic [31:0] CFG_RESET = 32'h0000_7700;

   // fields of the status register
   localparam int STS_TVAL_LSB = 0;
   localparam int STS_TUNK_LSB = 4;
   localparam int STS_CVAL_LSB = 8;
   localparam int STS_CUNK_LSB = 12;
   localparam int STS_ERR_BIT  = 16;

   localparam logic [NUM_BITS-1:0] OUTSEL_RESET = 4'h0;

   // both-active resolution codes
   localparam logic [2:0] CODE_L    = 3'h0;
   localparam logic [2:0] CODE_H    = 3'h1;
   localparam logic [2:0] CODE_N    = 3'h2;
   localparam logic [2:0] CODE_T    = 3'h3;
   localparam logic [2:0] CODE_X    = 3'h4;
   localparam logic [2:0] CODE_NONE = 3'h7;

   // next-value equation selection
   localparam logic [1:0] EQN_D   = 2'h0;
   localparam logic [1:0] EQN_JK  = 2'h1;
   localparam logic [1:0] EQN_DSC = 2'h2;

   typedef struct packed {
      logic unk;
      logic val;
   } cfbank_bit_s;

   localparam cfbank_bit_s BIT_ZERO = 2'h0;
   localparam cfbank_bit_s BIT_ONE  = 2'h1;
   localparam cfbank_bit_s BIT_UNK  = 2'h2;

   function automatic cfbank_bit_s bit_inv(input cfbank_bit_s b);
      bit_inv = '{unk: b.unk, val: b.unk ? 1'b0 : ~b.val};
   endfunction

   // output value while clear and preset are both active
   function automatic cfbank_bit_s resolve(input logic [2:0]  code,
                                           input cfbank_bit_s cur,
                                           input logic        entering);
      case (code)
         CODE_L:  resolve = BIT_ZERO;
         CODE_H:  resolve = BIT_ONE;
         CODE_N:  resolve = cur;
         CODE_T:  resolve = entering ? bit_inv(cur) : cur;
         default: resolve = BIT_UNK;
      endcase
   endfunction

   // next value; never reads the complement
   function automatic cfbank_bit_s next_value(input logic [1:0]  eqn,
                                              input logic        d,
                                              input logic        j,
                                              input logic        k,
                                              input logic        sclr,
                                              input cfbank_bit_s cur_true);
      case (eqn)
         EQN_JK:
         begin
            if (j && k)
               next_value = bit_inv(cur_true);
            else if (j)
               next_value = BIT_ONE;
            else if (k)
               next_value = BIT_ZERO;
            else
               next_value = cur_true;
         end
         EQN_DSC: next_value = '{unk: 1'b0, val: d & ~sclr};
         default: next_value = '{unk: 1'b0, val: d};
      endcase
   endfunction

endpackage

// ==== logic/cfbank_edge.sv ====
// edge detector for the capture and transfer clock expressions
`timescale 1ns/10ps
module cfbank_edge
(
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic cap_clk_in,
   input  wire logic xfer_clk_in,
   input  wire logic cap_inv_in,
   input  wire logic xfer_inv_in,
   output logic      cap_edge_out,
   output logic      xfer_edge_out
);

   typedef struct packed {
      logic cap_prev;
      logic xfer_prev;
   } cfbank_edge_s;

   cfbank_edge_s st_q;
   cfbank_edge_s st_d;
   logic         cap_expr;
   logic         xfer_expr;

   always_comb
   begin
      // inverted expression turns a falling pin edge into the active one
      cap_expr       = cap_clk_in ^ cap_inv_in;
      xfer_expr      = xfer_clk_in ^ xfer_inv_in;
      st_d.cap_prev  = cap_expr;
      st_d.xfer_prev = xfer_expr;
      cap_edge_out   = cap_expr & ~st_q.cap_prev;
      xfer_edge_out  = xfer_expr & ~st_q.xfer_prev;
   end

   // prev starts high so that a high level at release is not taken as an edge
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         st_q <= 2'h3;
      else
         st_q <= st_d;
   end

endmodule

// ==== logic/cfbank_cell.sv ====
// one storage bit: single-stage or master-slave with clear and preset
`timescale 1ns/10ps
module cfbank_cell
(
   input  wire logic                     clk_in,
   input  wire logic                     rst_n_in,
   input  wire logic                     ms_in,
   input  wire logic [2:0]               code_true_in,
   input  wire logic [2:0]               code_comp_in,
   input  wire logic                     cap_edge_in,
   input  wire logic                     xfer_edge_in,
   input  wire logic                     clr_in,
   input  wire logic                     pre_in,
   input  wire cfbank_pkg::cfbank_bit_s  nv_in,
   output cfbank_pkg::cfbank_bit_s       state_true_out,
   output cfbank_pkg::cfbank_bit_s       state_complement_out
);

   typedef struct packed {
      cfbank_pkg::cfbank_bit_s master_true;
      cfbank_pkg::cfbank_bit_s master_comp;
      cfbank_pkg::cfbank_bit_s slave_true;
      cfbank_pkg::cfbank_bit_s slave_comp;
      logic                    both_prev;
   } cfbank_cell_s;

   cfbank_cell_s st_q;
   cfbank_cell_s st_d;
   logic         both;
   logic         entering;

   always_comb
   begin
      st_d     = st_q;
      both     = clr_in & pre_in;
      entering = both & ~st_q.both_prev;
      st_d.both_prev = both;
      if (both)
      begin
         // toggle acts once on entry, then holds
         st_d.master_true = cfbank_pkg::resolve(code_true_in, st_q.slave_true,
                                                entering);
         st_d.master_comp = cfbank_pkg::resolve(code_comp_in, st_q.slave_comp,
                                                entering);
         st_d.slave_true  = st_d.master_true;
         st_d.slave_comp  = st_d.master_comp;
      end
      else if (clr_in)
      begin
         st_d.master_true = cfbank_pkg::BIT_ZERO;
         st_d.master_comp = cfbank_pkg::BIT_ONE;
         st_d.slave_true  = cfbank_pkg::BIT_ZERO;
         st_d.slave_comp  = cfbank_pkg::BIT_ONE;
      end
      else if (pre_in)
      begin
         st_d.master_true = cfbank_pkg::BIT_ONE;
         st_d.master_comp = cfbank_pkg::BIT_ZERO;
         st_d.slave_true  = cfbank_pkg::BIT_ONE;
         st_d.slave_comp  = cfbank_pkg::BIT_ZERO;
      end
      else
      begin
         if (cap_edge_in)
         begin
            st_d.master_true = nv_in;
            st_d.master_comp = cfbank_pkg::bit_inv(nv_in);
         end
         if (!ms_in)
         begin
            // single stage: no transfer clock, outputs follow the capture
            st_d.slave_true = st_d.master_true;
            st_d.slave_comp = st_d.master_comp;
         end
         else if (xfer_edge_in)
         begin
            st_d.slave_true = st_q.master_true;
            st_d.slave_comp = st_q.master_comp;
         end
      end
      state_true_out       = st_q.slave_true;
      state_complement_out = st_q.slave_comp;
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         st_q <= '{master_true: 2'h0, master_comp: 2'h1,
                   slave_true: 2'h0, slave_comp: 2'h1, both_prev: 1'b0};
      else
         st_q <= st_d;
   end

endmodule

// ==== logic/cfbank_top.sv ====
// multibit storage group with APB configuration and status
// Functional notes
// - With clear and preset idle a capture edge loads the next value and its inverse.
// - Clear alone gives true 0, complement 1, preset alone the reverse, with no clock.
// - With clear and preset both active each output takes its own resolution code.
// - Code L gives 0 and code H gives 1 while both stay active.
// - Code N holds, code T inverts with unknown kept, code X gives unknown.
// - A configuration needs a code if both controls exist and both controls if any code.
// - Any change of clear, preset or either clock re-evaluates the state.
// - A plain capture clock captures on rising edges, an inverted one on falling.
// - Single stage uses no transfer clock.
// - Master-slave: master loads on capture, slave copies master on transfer.
// - Clear, preset and resolution codes force master and slave alike.
// - The next value may use inputs and the true state, never the complement.
// - JK: both high toggles, J alone sets, K alone resets, both low holds.
// - Synchronous clear gates data with inverted clear, acting only on capture.
// - The bank holds identical bits sharing clock, clear and preset.
// - Each output bit comes from its own bit's true or complement state.
//
// The APB register port and the address map were decided locally.
`timescale 1ns/10ps
module cfbank_top
(
   input  wire logic                          SYS_CLK_IN,
   input  wire logic                          RST_N_IN,
   input  wire logic                          PSEL_IN,
   input  wire logic                          PENABLE_IN,
   input  wire logic                          PWRITE_IN,
   input  wire logic [7:0]                    PADDR_IN,
   input  wire logic [31:0]                   PWDATA_IN,
   output logic                               PREADY_OUT,
   output logic [31:0]                        PRDATA_OUT,
   output logic                               PSLVERR_OUT,
   input  wire logic                          CAP_CLK_IN,
   input  wire logic                          XFER_CLK_IN,
   input  wire logic                          CLEAR_IN,
   input  wire logic                          PRESET_IN,
   input  wire logic                          SYNC_CLEAR_IN,
   input  wire logic [cfbank_pkg::NUM_BITS-1:0] D_IN,
   input  wire logic [cfbank_pkg::NUM_BITS-1:0] J_IN,
   input  wire logic [cfbank_pkg::NUM_BITS-1:0] K_IN,
   output logic [cfbank_pkg::NUM_BITS-1:0]    Q_OUT,
   output logic [cfbank_pkg::NUM_BITS-1:0]    Q_UNKNOWN_OUT
);

   localparam int NB = cfbank_pkg::NUM_BITS;

   typedef struct packed {
      logic [31:0]   cfg;
      logic [NB-1:0] outsel;
      logic          cfg_err;
      logic          pready;
      logic [31:0]   prdata;
      logic          pslverr;
      logic [NB-1:0] q;
      logic [NB-1:0] q_unk;
   } cfbank_top_s;

   cfbank_top_s st_q;
   cfbank_top_s st_d;

   logic                    cap_edge;
   logic                    xfer_edge;
   logic                    clr_act;
   logic                    pre_act;
   logic                    setup;
   logic [31:0]             wcfg;
   logic [31:0]             status;
   cfbank_pkg::cfbank_bit_s state_true       [NB];
   cfbank_pkg::cfbank_bit_s state_complement [NB];
   cfbank_pkg::cfbank_bit_s nv               [NB];

   // true when a candidate configuration word is self-consistent
   function automatic logic cfg_ok(input logic [31:0] c);
      logic       both_exist;
      logic       some_code;
      logic [2:0] ct;
      logic [2:0] cc;
      ct         = c[cfbank_pkg::CFG_CODE_T_LSB +: 3];
      cc         = c[cfbank_pkg::CFG_CODE_C_LSB +: 3];
      both_exist = c[cfbank_pkg::CFG_CLR_EN_BIT] & c[cfbank_pkg::CFG_PRE_EN_BIT];
      some_code  = (ct != cfbank_pkg::CODE_NONE) || (cc != cfbank_pkg::CODE_NONE);
      cfg_ok     = (both_exist == some_code) && (c[cfbank_pkg::CFG_EQN_LSB +: 2] != 2'h3)
                   && (ct <= cfbank_pkg::CODE_X || ct == cfbank_pkg::CODE_NONE)
                   && (cc <= cfbank_pkg::CODE_X || cc == cfbank_pkg::CODE_NONE);
   endfunction

   // shared capture and transfer edges feed every bit
   cfbank_edge u_edge
   (
      .clk_in        (SYS_CLK_IN),
      .rst_n_in      (RST_N_IN),
      .cap_clk_in    (CAP_CLK_IN),
      .xfer_clk_in   (XFER_CLK_IN),
      .cap_inv_in    (st_q.cfg[cfbank_pkg::CFG_CAP_INV_BIT]),
      .xfer_inv_in   (st_q.cfg[cfbank_pkg::CFG_XFER_INV_BIT]),
      .cap_edge_out  (cap_edge),
      .xfer_edge_out (xfer_edge)
   );

   always_comb
   begin
      // a control that is not configured present is never active
      clr_act = st_q.cfg[cfbank_pkg::CFG_CLR_EN_BIT] &
                (CLEAR_IN ^ st_q.cfg[cfbank_pkg::CFG_CLR_LOW_BIT]);
      pre_act = st_q.cfg[cfbank_pkg::CFG_PRE_EN_BIT] &
                (PRESET_IN ^ st_q.cfg[cfbank_pkg::CFG_PRE_LOW_BIT]);
   end

   for (genvar i = 0; i < NB; i++)
   begin : g_bit
      always_comb
      begin
         nv[i] = cfbank_pkg::next_value(st_q.cfg[cfbank_pkg::CFG_EQN_LSB +: 2],
                                        D_IN[i], J_IN[i], K_IN[i], SYNC_CLEAR_IN,
                                        state_true[i]);
      end

      cfbank_cell u_cell
      (
         .clk_in               (SYS_CLK_IN),
         .rst_n_in             (RST_N_IN),
         .ms_in                (st_q.cfg[cfbank_pkg::CFG_MS_BIT]),
         .code_true_in         (st_q.cfg[cfbank_pkg::CFG_CODE_T_LSB +: 3]),
         .code_comp_in         (st_q.cfg[cfbank_pkg::CFG_CODE_C_LSB +: 3]),
         .cap_edge_in          (cap_edge),
         .xfer_edge_in         (xfer_edge),
         .clr_in               (clr_act),
         .pre_in               (pre_act),
         .nv_in                (nv[i]),
         .state_true_out       (state_true[i]),
         .state_complement_out (state_complement[i])
      );
   end

   always_comb
   begin
      status = 32'h0000_0000;
      for (int i = 0; i < NB; i++)
      begin
         status[cfbank_pkg::STS_TVAL_LSB + i] = state_true[i].val;
         status[cfbank_pkg::STS_TUNK_LSB + i] = state_true[i].unk;
         status[cfbank_pkg::STS_CVAL_LSB + i] = state_complement[i].val;
         status[cfbank_pkg::STS_CUNK_LSB + i] = state_complement[i].unk;
      end
      status[cfbank_pkg::STS_ERR_BIT] = st_q.cfg_err;
   end

   always_comb
   begin
      st_d  = st_q;
      setup = PSEL_IN & ~PENABLE_IN;
      wcfg  = PWDATA_IN & cfbank_pkg::CFG_WMASK;
      // fixed one-cycle answer, no wait states
      st_d.pready  = setup;
      st_d.pslverr = 1'b0;
      st_d.prdata  = 32'h0000_0000;
      if (setup)
      begin
         if (PADDR_IN == cfbank_pkg::ADDR_CFG)
            st_d.prdata = st_q.cfg;
         else if (PADDR_IN == cfbank_pkg::ADDR_OUTSEL)
            st_d.prdata = {{(32 - NB){1'b0}}, st_q.outsel};
         else if (PADDR_IN == cfbank_pkg::ADDR_STATUS)
            st_d.prdata = status;
         else
            st_d.pslverr = 1'b1;
         if (PWRITE_IN)
            st_d.prdata = 32'h0000_0000;
         if (PWRITE_IN && PADDR_IN == cfbank_pkg::ADDR_STATUS)
            st_d.pslverr = 1'b1;
      end
      // writes land only at the access edge
      if (PSEL_IN && PENABLE_IN && st_q.pready && PWRITE_IN)
      begin
         if (PADDR_IN == cfbank_pkg::ADDR_CFG)
         begin
            // a rejected word leaves the old setup running
            if (cfg_ok(wcfg))
            begin
               st_d.cfg     = wcfg;
               st_d.cfg_err = 1'b0;
            end
            else
               st_d.cfg_err = 1'b1;
         end
         else if (PADDR_IN == cfbank_pkg::ADDR_OUTSEL)
            st_d.outsel = PWDATA_IN[NB-1:0];
      end
      for (int i = 0; i < NB; i++)
      begin
         st_d.q[i]     = st_q.outsel[i] ? state_complement[i].val
                                        : state_true[i].val;
         st_d.q_unk[i] = st_q.outsel[i] ? state_complement[i].unk
                                        : state_true[i].unk;
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         st_q <= '{cfg: cfbank_pkg::CFG_RESET, outsel: cfbank_pkg::OUTSEL_RESET,
                   cfg_err: 1'b0, pready: 1'b0, prdata: 32'h0000_0000,
                   pslverr: 1'b0, q: 4'h0, q_unk: 4'h0};
      else
         st_q <= st_d;
   end

   always_comb
   begin
      PREADY_OUT    = st_q.pready;
      PRDATA_OUT    = st_q.prdata;
      PSLVERR_OUT   = st_q.pslverr;
      Q_OUT         = st_q.q;
      Q_UNKNOWN_OUT = st_q.q_unk;
   end

endmodule

// ==== verif/cfbank_asserts.sv ====
// concurrent checks of the flip-flop bank at its top-level pins
`timescale 1ns/10ps
module cfbank_asserts
(
   input wire logic        SYS_CLK_IN,
   input wire logic        RST_N_IN,
   input wire logic        PSEL_IN,
   input wire logic        PENABLE_IN,
   input wire logic        PWRITE_IN,
   input wire logic [7:0]  PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   input wire logic        PREADY_OUT,
   input wire logic [31:0] PRDATA_OUT,
   input wire logic        PSLVERR_OUT,
   input wire logic        CLEAR_IN,
   input wire logic        PRESET_IN,
   input wire logic [3:0]  Q_OUT,
   input wire logic [3:0]  Q_UNKNOWN_OUT
);
   logic [31:0] cfg_q;
   logic [3:0]  os_q;
   logic        err_q, setup, wr_done, clr_act, pre_act, both;
   assign setup   = PSEL_IN && !PENABLE_IN;
   assign wr_done = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
   assign clr_act = cfg_q[3] && (CLEAR_IN ^ cfg_q[5]);
   assign pre_act = cfg_q[4] && (PRESET_IN ^ cfg_q[6]);
   assign both    = clr_act && pre_act;

   // configuration shadow for active levels and codes
   function automatic logic cfg_ok(input logic [31:0] w);
      logic any;
      any = (w[10:8] != 3'h7) || (w[14:12] != 3'h7);
      cfg_ok = (w[10:8] < 3'h5 || w[10:8] == 3'h7) && (w[14:12] < 3'h5 || w[14:12] == 3'h7)
               && w[17:16] != 2'h3 && (any == (w[3] && w[4]));
   endfunction

   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         cfg_q <= cfbank_pkg::CFG_RESET;
         os_q  <= 4'h0;
         err_q <= 1'b0;
      end
      else if (wr_done && PADDR_IN == cfbank_pkg::ADDR_CFG)
      begin
         cfg_q <= cfg_ok(PWDATA_IN) ? (PWDATA_IN & cfbank_pkg::CFG_WMASK) : cfg_q;
         err_q <= !cfg_ok(PWDATA_IN);
      end
      else if (wr_done && PADDR_IN == cfbank_pkg::ADDR_OUTSEL)
         os_q <= PWDATA_IN[3:0];
   end

   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RST_N_IN);

   a_ready_after_setup: assert property (setup |=> PREADY_OUT)
      else $error("no ready");
   a_ready_one_cycle: assert property (PREADY_OUT |=> !PREADY_OUT)
      else $error("ready held");
   a_rdata_idle_zero: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0)
      else $error("stray read data");
   a_unmapped_error: assert property (setup && PADDR_IN != cfbank_pkg::ADDR_CFG
      && PADDR_IN != cfbank_pkg::ADDR_OUTSEL && PADDR_IN != cfbank_pkg::ADDR_STATUS
      |=> PSLVERR_OUT) else $error("no slave error");
   a_cfg_readback: assert property (setup && !PWRITE_IN && PADDR_IN == cfbank_pkg::ADDR_CFG
      |=> PRDATA_OUT == cfg_q) else $error("bad readback");
   a_status_error: assert property (setup && !PWRITE_IN && PADDR_IN == cfbank_pkg::ADDR_STATUS
      |=> PRDATA_OUT[16] == err_q) else $error("bad error flag");
   a_clear_alone: assert property ((clr_act && !pre_act)[*2]
      |=> Q_OUT == os_q && Q_UNKNOWN_OUT == 4'h0) else $error("clear failed");
   a_preset_alone: assert property ((pre_act && !clr_act)[*2]
      |=> Q_OUT == ~os_q && Q_UNKNOWN_OUT == 4'h0) else $error("preset failed");
   a_both_fixed_level: assert property ((both && cfg_q[10:8] == cfg_q[14:12]
      && cfg_q[10:9] == 2'h0)[*2] |=> Q_OUT == {4{cfg_q[8]}} && Q_UNKNOWN_OUT == 4'h0)
      else $error("bad fixed level");
   a_both_unknown: assert property ((both && cfg_q[10:8] == cfbank_pkg::CODE_X
      && cfg_q[14:12] == cfbank_pkg::CODE_X)[*2] |=> Q_UNKNOWN_OUT == 4'hF)
      else $error("unknown not flagged");
   a_toggle_once: assert property ((both && cfg_q[10:8] == cfbank_pkg::CODE_T
      && cfg_q[14:12] == cfbank_pkg::CODE_T)[*4] |-> $stable(Q_OUT))
      else $error("toggle repeated");
endmodule

bind cfbank_top cfbank_asserts cfbank_asserts_i (.*);

// ==== verif/cfbank_pins.sv ====
// pin driver for the logic around the flip-flop bank
`timescale 1ns/10ps
module cfbank_pins
(
   input  wire logic                        clk_in,
   output logic                             cap_out,
   output logic                             xfer_out,
   output logic                             clr_out,
   output logic                             pre_out,
   output logic                             sclr_out,
   output logic [cfbank_pkg::NUM_BITS-1:0]  d_out,
   output logic [cfbank_pkg::NUM_BITS-1:0]  j_out,
   output logic [cfbank_pkg::NUM_BITS-1:0]  k_out
);
   initial
   begin
      {cap_out, xfer_out, clr_out, pre_out, sclr_out} = 5'h00;
      {d_out, j_out, k_out} = 12'h000;
   end

   // each level stays at least one system cycle, or the sampler would miss it
   task automatic set_clk(input logic xfer, input logic v, input int hold);
      @(posedge clk_in);
      if (xfer)
         xfer_out <= v;
      else
         cap_out <= v;
      repeat (hold) @(posedge clk_in);
   endtask

   task automatic set_ctl(input logic c, input logic p);
      @(posedge clk_in);
      clr_out <= c;
      pre_out <= p;
   endtask

   task automatic set_in(input logic [3:0] d, input logic [3:0] j, input logic [3:0] k,
                         input logic s);
      @(posedge clk_in);
      d_out    <= d;
      j_out    <= j;
      k_out    <= k;
      sclr_out <= s;
   endtask
endmodule

// ==== verif/tb_top.sv ====
// self-checking bench of the flip-flop bank
`timescale 1ns/10ps
module tb_top;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        qprobe = 1'b0;
   logic        pready, pslverr, cap, xfer, clr, pre, sclr;
   logic [31:0] prdata;
   logic [3:0]  q, qu, dp, jp, kp;
   logic [33:0] rd_q[$];
   logic [7:0]  q_q[$];
   logic [33:0] rexp;
   logic [7:0]  qexp;
   int          mismatches = 0;
   int          compares = 0;
   int          cyc = 0;
   logic [31:0] seed = 32'hB1DA;
   logic [3:0]  et = 4'h0, eu = 4'h0, ec = 4'hF, os = 4'h0, d = 4'h0;
   logic [31:0] bad[4] = '{32'h0000_7718, 32'h0000_0708, 32'h0000_3618, 32'h0003_0018};
   logic [2:0]  codes[5] = '{cfbank_pkg::CODE_L, cfbank_pkg::CODE_H, cfbank_pkg::CODE_N,
                             cfbank_pkg::CODE_T, cfbank_pkg::CODE_X};
   // outcome of each code entered from preset
   logic [3:0]  tv[5] = '{4'h0, 4'hF, 4'hF, 4'h0, 4'h0};
   logic [3:0]  cv[5] = '{4'h0, 4'hF, 4'h0, 4'hF, 4'h0};
   logic [3:0]  uv[5] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'hF};

   always #12.5 clk = ~clk;

   cfbank_top cfbank_top_i (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
      .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
      .PREADY_OUT(pready), .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr), .CAP_CLK_IN(cap),
      .XFER_CLK_IN(xfer), .CLEAR_IN(clr), .PRESET_IN(pre), .SYNC_CLEAR_IN(sclr), .D_IN(dp),
      .J_IN(jp), .K_IN(kp), .Q_OUT(q), .Q_UNKNOWN_OUT(qu));
   cfbank_pins cfbank_pins_i (.clk_in(clk), .cap_out(cap), .xfer_out(xfer), .clr_out(clr),
      .pre_out(pre), .sclr_out(sclr), .d_out(dp), .j_out(jp), .k_out(kp));

   function automatic logic [3:0] rnd4();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[3:0];
   endfunction

   task automatic print_verdict();
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %0t %h exp %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] w,
                      input logic err, input logic [31:0] exp);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= w;
      rd_q.push_back({~wr, err, exp});
      @(posedge clk);
      penable <= 1'b1;
      // only the bench timeout ends a wait
      do
         @(posedge clk);
      while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic cfg(input logic [31:0] w);
      apb(1'b1, cfbank_pkg::ADDR_CFG, w, 1'b0, 32'h0);
   endtask

   // status and selected outputs
   task automatic chk(input logic err);
      repeat (3) @(posedge clk);
      apb(1'b0, cfbank_pkg::ADDR_STATUS, 32'h0, 1'b0, {15'h0, err, eu, ec, eu, et});
      @(posedge clk);
      qprobe <= 1'b1;
      q_q.push_back({eu, (et & ~os) | (ec & os)});
      @(posedge clk);
      qprobe <= 1'b0;
   endtask

   task automatic st(input logic [3:0] t, input logic [3:0] c, input logic [3:0] u);
      et = t;
      ec = c;
      eu = u;
   endtask

   task automatic drive(input logic [3:0] dv, input logic [3:0] j, input logic [3:0] k,
                        input logic s);
      d = dv;
      cfbank_pins_i.set_in(dv, j, k, s);
   endtask

   // random hold of one to three cycles
   task automatic pin(input logic x, input logic v);
      cfbank_pins_i.set_clk(x, v, int'(rnd4() % 4'h3) + 1);
   endtask

   task automatic pulse(input logic x);
      pin(x, 1'b1);
      pin(x, 1'b0);
   endtask

   always @(posedge clk)
   begin
      if (psel && penable && pready === 1'b1 && rd_q.size() > 0)
      begin
         rexp = rd_q.pop_front();
         cmp({31'h0, pslverr}, {31'h0, rexp[32]});
         if (rexp[33])
            cmp(prdata, rexp[31:0]);
      end
      if (qprobe && q_q.size() > 0)
      begin
         qexp = q_q.pop_front();
         cmp({24'h0, qu, q}, {24'h0, qexp});
      end
   end

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 12000)
      begin
         mismatches++;
         print_verdict();
      end
   end

   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, cfbank_pkg::ADDR_CFG, 32'h0, 1'b0, cfbank_pkg::CFG_RESET);
      apb(1'b0, cfbank_pkg::ADDR_OUTSEL, 32'h0, 1'b0, 32'h0);
      chk(1'b0);
      apb(1'b0, 8'h0C, 32'h0, 1'b1, 32'h0);
      apb(1'b1, 8'h10, 32'hFFFF_FFFF, 1'b1, 32'h0);
      apb(1'b1, cfbank_pkg::ADDR_STATUS, 32'hFFFF_FFFF, 1'b1, 32'h0);
      foreach (bad[i])
      begin
         cfg(bad[i]);
         chk(1'b1);
         apb(1'b0, cfbank_pkg::ADDR_CFG, 32'h0, 1'b0, cfbank_pkg::CFG_RESET);
      end
      cfg(32'h18);
      os = rnd4();
      apb(1'b1, cfbank_pkg::ADDR_OUTSEL, {28'h0, os}, 1'b0, 32'h0);
      apb(1'b0, cfbank_pkg::ADDR_OUTSEL, 32'h0, 1'b0, {28'h0, os});
      drive(rnd4(), 4'h0, 4'h0, 1'b0);
      pin(1'b0, 1'b1);
      st(d, ~d, 4'h0);
      chk(1'b0);
      // pin high as inversion starts, so the write makes no edge
      cfg(32'h1A);
      drive(rnd4(), 4'h0, 4'h0, 1'b0);
      pin(1'b0, 1'b0);
      st(d, ~d, 4'h0);
      chk(1'b0);
      drive(rnd4(), 4'h0, 4'h0, 1'b0);
      pin(1'b0, 1'b1);
      pulse(1'b1);
      chk(1'b0);
      pin(1'b0, 1'b0);
      st(d, ~d, 4'h0);
      cfg(32'h18);
      foreach (codes[i])
      begin
         cfg(32'h18 | {codes[i], 1'b0, codes[i], 8'h00});
         cfbank_pins_i.set_ctl(1'b0, 1'b1);
         st(4'hF, 4'h0, 4'h0);
         chk(1'b0);
         cfbank_pins_i.set_ctl(1'b1, 1'b1);
         st(tv[i], cv[i], uv[i]);
         repeat (4) @(posedge clk);
         chk(1'b0);
         cfbank_pins_i.set_ctl(1'b1, 1'b0);
         drive(4'hF, 4'h0, 4'h0, 1'b0);
         pulse(1'b0);
         st(4'h0, 4'hF, 4'h0);
         chk(1'b0);
         cfbank_pins_i.set_ctl(1'b0, 1'b0);
      end
      cfg(32'h1_0018);
      cfbank_pins_i.set_ctl(1'b0, 1'b1);
      cfbank_pins_i.set_ctl(1'b0, 1'b0);
      drive(4'h0, 4'h3, 4'h5, 1'b0);
      pulse(1'b0);
      st(4'hA, 4'h5, 4'h0);
      chk(1'b0);
      cfg(32'h2_0018);
      drive(4'hF, 4'h0, 4'h0, 1'b0);
      pulse(1'b0);
      drive(4'hF, 4'h0, 4'h0, 1'b1);
      st(4'hF, 4'h0, 4'h0);
      chk(1'b0);
      pulse(1'b0);
      st(4'h0, 4'hF, 4'h0);
      chk(1'b0);
      cfg(32'h1119);
      drive(rnd4(), 4'h0, 4'h0, 1'b0);
      pulse(1'b0);
      chk(1'b0);
      pulse(1'b1);
      st(d, ~d, 4'h0);
      chk(1'b0);
      cfbank_pins_i.set_ctl(1'b1, 1'b1);
      cfbank_pins_i.set_ctl(1'b0, 1'b0);
      pulse(1'b1);
      st(4'hF, 4'hF, 4'h0);
      chk(1'b0);
      print_verdict();
   end
endmodule
